// >>> hdl/pdc_cfg.svh
// Timing and geometry constants for the page-mode DRAM controller.
`ifndef PDC_CFG_SVH
`define PDC_CFG_SVH
`define PDC_CLK_MHZ 25
`define PDC_CYC(ns) (((ns) * `PDC_CLK_MHZ + 999) / 1000 < 1 ? 1 : ((ns) * `PDC_CLK_MHZ + 999) / 1000)
`define PDC_ADDR_W 11
`define PDC_DATA_W 4
`define PDC_ROWS 2048
`define PDC_INIT_CYCLES 8
`define PDC_POWERUP_US 200
`define PDC_IDLE_MS 32
`define PDC_REFRESH_MS 32
`define PDC_T_RAS_NS 60
`define PDC_T_RP_NS 40
`define PDC_T_ROW_COL_NS 20
`define PDC_T_ROW_HOLD_NS 10
`define PDC_T_CAS_NS 15
`define PDC_T_CP_NS 10
`define PDC_T_PC_NS 40
`define PDC_T_PG_RMW_NS 85
`define PDC_T_PRE_ACC_NS 35
`define PDC_T_PRE_HOLD_NS 35
`define PDC_T_OE_DATA_NS 15
`define PDC_T_COL_WR_NS 40
`define PDC_T_RASP_MAX_NS 10000
`define PDC_PAGE_MARGIN_CYC 16
`define PDC_T_CSR_NS 5
`define PDC_T_CHR_NS 10
`define PDC_T_TEST_EXTRA_NS 5
`endif

// >>> hdl/pdc_pkg.sv
// Types shared by the page-mode DRAM controller.
package pdc_pkg;
  typedef enum logic [1:0] {PDC_RD, PDC_WR, PDC_RMW} pdc_op_e;
  typedef struct packed {
    logic rasN;
    logic casN;
    logic weN;
    logic oeN;
    logic [10:0] addr;
    logic [3:0] dqOut;
    logic dqOe;
  } pdc_pins_s;
  typedef struct packed {
    logic valid;
    pdc_op_e op;
    logic [10:0] row;
    logic [10:0] col;
    logic [3:0] wdata;
    logic last;
  } pdc_req_s;
endpackage

// >>> hdl/pdc_ctrl.sv
// Controller that drives an asynchronous page-mode DRAM through its strobe pins.
// Notes on behaviour
// - Wait 200 us, then eight row-strobe cycles.
// - After 32 ms idle, eight wake-up cycles.
// - Eight column-first refreshes before using counter.
// - Row half on row fall, column on column.
// - Write strobe high before column fall for read.
// - Write strobe held high after read cycle.
// - Write data referenced to column or write fall.
// - Raise output enable before driving write data.
// - Respect output-enable-to-data delay.
// - Page column spacing 40 ns, 85 ns read-write.
// - Page row strobe low 60 ns to 10k ns.
// - Data valid 35 ns after precharge; hold row.
// - Column low, write high: refresh; both low: test.
// - Refresh all 2048 rows every 32 ms.
// - Page mode toggles column with row held low.
`include "pdc_cfg.svh"
module pdc_ctrl #(
  parameter int unsigned POWERUP_CYC = `PDC_POWERUP_US * `PDC_CLK_MHZ,
  parameter int unsigned IDLE_CYC = `PDC_IDLE_MS * 1000 * `PDC_CLK_MHZ,
  parameter int unsigned REFRESH_CYC = `PDC_REFRESH_MS * 1000 * `PDC_CLK_MHZ / `PDC_ROWS,
  parameter bit TEST_MODE = 1'b0
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire pdc_pkg::pdc_req_s req,
  output logic reqReady,
  output logic [3:0] rdData,
  output logic rdValid,
  output logic initDone,
  output pdc_pkg::pdc_pins_s pins,
  input wire logic [3:0] dqIn
);
  localparam int unsigned TEX = TEST_MODE ? `PDC_T_TEST_EXTRA_NS : 0;
  localparam logic [7:0] C_RP = 8'(`PDC_CYC(`PDC_T_RP_NS));
  localparam logic [7:0] C_RAS = 8'(`PDC_CYC(`PDC_T_RAS_NS));
  localparam logic [7:0] C_R2C = 8'(`PDC_CYC(`PDC_T_ROW_COL_NS));
  localparam logic [7:0] C_CP = 8'(`PDC_CYC(`PDC_T_CP_NS));
  localparam logic [7:0] C_ACC = 8'(`PDC_CYC(`PDC_T_PRE_ACC_NS + TEX));
  localparam logic [7:0] C_RWG = 8'(`PDC_CYC(`PDC_T_COL_WR_NS + `PDC_T_PG_RMW_NS - `PDC_T_PC_NS));
  localparam logic [7:0] C_OE2D = 8'(`PDC_CYC(`PDC_T_OE_DATA_NS));
  localparam logic [7:0] C_HOLD = 8'(`PDC_CYC(`PDC_T_PRE_HOLD_NS));
  localparam logic [7:0] C_CSR = 8'(`PDC_CYC(`PDC_T_CSR_NS + `PDC_T_CHR_NS));
  localparam logic [31:0] C_PAGE = 32'(`PDC_T_RASP_MAX_NS * `PDC_CLK_MHZ / 1000);

  typedef enum logic [3:0] {
    S_PWR, S_INIT, S_IDLE, S_ROW, S_COL, S_ACC, S_WDAT, S_PRE, S_RHOLD, S_RP, S_REFR
  } pdc_state_e;

  typedef struct packed {
    pdc_state_e st;
    logic [31:0] longCnt;
    logic [31:0] refCnt;
    logic [7:0] cnt;
    logic [3:0] initCnt;
    logic [11:0] refOwed;
    pdc_pkg::pdc_req_s cur;
    pdc_pkg::pdc_pins_s pins;
    logic ready;
    logic [3:0] rd;
    logic rdv;
    logic done;
  } pdc_state_s;

  pdc_state_s s_r;
  pdc_state_s s_nxt;

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ready = 1'b0;
    s_nxt.rdv = 1'b0;
    if (s_r.cnt != 8'h00)
      s_nxt.cnt = s_r.cnt - 8'h01;
    if (s_r.longCnt != 32'h0)
      s_nxt.longCnt = s_r.longCnt - 32'h1;
    if (s_r.refCnt != 32'h0)
      s_nxt.refCnt = s_r.refCnt - 32'h1;
    else if (s_r.done)
    begin
      s_nxt.refCnt = REFRESH_CYC;
      s_nxt.refOwed = s_r.refOwed + 12'h001;
    end
    unique case (s_r.st)
      S_PWR:
      begin
        if (s_r.longCnt == 32'h0)
        begin
          s_nxt.st = S_RP;
          s_nxt.initCnt = 4'(`PDC_INIT_CYCLES);
        end
      end
      S_INIT:
      begin
        // Wake-up cycles are column-first refreshes so they also prime the counter.
        if (s_r.cnt == 8'h00)
        begin
          s_nxt.st = S_REFR;
          s_nxt.pins.casN = 1'b0;
          s_nxt.pins.weN = 1'b1;
          s_nxt.cnt = C_CSR;
        end
      end
      S_REFR:
      begin
        if (s_r.pins.rasN && s_r.cnt == 8'h00)
        begin
          s_nxt.pins.rasN = 1'b0;
          s_nxt.cnt = C_RAS;
        end
        else if (!s_r.pins.rasN && s_r.cnt == 8'h00)
        begin
          s_nxt.pins.rasN = 1'b1;
          s_nxt.pins.casN = 1'b1;
          s_nxt.st = S_RP;
          if (s_r.initCnt != 4'h0)
            s_nxt.initCnt = s_r.initCnt - 4'h1;
          else if (s_r.refOwed != 12'h000)
            s_nxt.refOwed = s_nxt.refOwed - 12'h001;
        end
      end
      S_RP:
      begin
        if (s_r.cnt == 8'h00)
        begin
          s_nxt.cnt = C_RP;
          s_nxt.st = (s_r.initCnt != 4'h0) ? S_INIT : S_IDLE;
          // Every finished row cycle is strobe activity, so the idle timer restarts here.
          s_nxt.longCnt = IDLE_CYC;
          if (s_r.initCnt == 4'h0 && !s_r.done)
          begin
            s_nxt.done = 1'b1;
            s_nxt.refCnt = REFRESH_CYC;
          end
        end
      end
      S_IDLE:
      begin
        if (s_r.cnt != 8'h00)
          s_nxt.st = S_IDLE;
        else if (s_r.longCnt == 32'h0)
        begin
          s_nxt.initCnt = 4'(`PDC_INIT_CYCLES);
          s_nxt.st = S_INIT;
        end
        else if (s_r.refOwed != 12'h000)
          s_nxt.st = S_INIT;
        else if (req.valid)
        begin
          s_nxt.cur = req;
          s_nxt.ready = 1'b1;
          // While the row is open the idle timer bounds its low time instead.
          s_nxt.longCnt = C_PAGE;
          s_nxt.pins.addr = req.row;
          s_nxt.pins.weN = 1'b1;
          s_nxt.pins.oeN = 1'b1;
          s_nxt.pins.rasN = 1'b0;
          s_nxt.cnt = C_RAS;
          s_nxt.st = S_ROW;
        end
      end
      S_ROW:
      begin
        // Column is driven only after row hold time; the strobe waits full row-to-column.
        if (s_r.cnt <= C_RAS - C_R2C)
        begin
          s_nxt.pins.addr = s_r.cur.col;
          s_nxt.st = S_COL;
        end
      end
      S_COL:
      begin
        s_nxt.pins.casN = 1'b0;
        if (s_r.cur.op == pdc_pkg::PDC_WR)
        begin
          s_nxt.pins.weN = 1'b0;
          s_nxt.pins.dqOut = s_r.cur.wdata;
          s_nxt.pins.dqOe = 1'b1;
        end
        else
        begin
          s_nxt.pins.weN = 1'b1;
          s_nxt.pins.oeN = 1'b0;
        end
        s_nxt.st = S_ACC;
        // Read-modify-write waits out the longer C_RWG gap; reads and writes wait C_ACC.
        s_nxt.cnt = (s_r.cur.op == pdc_pkg::PDC_RMW) ? C_RWG : C_ACC;
      end
      S_ACC:
      begin
        if (s_r.cnt == 8'h00)
        begin
          if (s_r.cur.op != pdc_pkg::PDC_WR)
          begin
            s_nxt.rd = dqIn;
            s_nxt.rdv = (s_r.cur.op == pdc_pkg::PDC_RD);
          end
          if (s_r.cur.op == pdc_pkg::PDC_RMW)
          begin
            s_nxt.pins.oeN = 1'b1;
            s_nxt.cnt = C_OE2D;
            s_nxt.st = S_WDAT;
            s_nxt.rdv = 1'b1;
          end
          else
          begin
            s_nxt.pins.casN = 1'b1;
            s_nxt.pins.oeN = 1'b1;
            s_nxt.cnt = C_CP;
            s_nxt.st = S_PRE;
          end
        end
      end
      S_WDAT:
      begin
        if (s_r.cnt == 8'h00 && !s_r.pins.dqOe)
        begin
          s_nxt.pins.dqOut = s_r.cur.wdata;
          s_nxt.pins.dqOe = 1'b1;
          s_nxt.pins.weN = 1'b0;
          s_nxt.cnt = C_CP;
        end
        else if (s_r.cnt == 8'h00)
        begin
          s_nxt.pins.casN = 1'b1;
          s_nxt.cnt = C_CP;
          s_nxt.st = S_PRE;
        end
      end
      S_PRE:
      begin
        s_nxt.pins.dqOe = 1'b0;
        s_nxt.pins.weN = 1'b1;
        if (s_r.cnt == 8'h00)
        begin
          if (!s_r.cur.last && req.valid && req.row == s_r.cur.row
              && s_r.longCnt > 32'(`PDC_PAGE_MARGIN_CYC))
          begin
            s_nxt.cur = req;
            s_nxt.ready = 1'b1;
            s_nxt.pins.addr = req.col;
            s_nxt.st = S_COL;
          end
          else
          begin
            s_nxt.cnt = C_HOLD;
            s_nxt.st = S_RHOLD;
          end
        end
      end
      S_RHOLD:
      begin
        if (s_r.cnt == 8'h00)
        begin
          s_nxt.pins.rasN = 1'b1;
          s_nxt.cnt = C_RP;
          s_nxt.st = S_RP;
        end
      end
      default:
        s_nxt.st = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s_r <= '0;
      s_r.st <= S_PWR;
      s_r.longCnt <= POWERUP_CYC;
      s_r.pins.rasN <= 1'b1;
      s_r.pins.casN <= 1'b1;
      s_r.pins.weN <= 1'b1;
      s_r.pins.oeN <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign reqReady = s_r.ready;
  assign rdData = s_r.rd;
  assign rdValid = s_r.rdv;
  assign initDone = s_r.done;
  assign pins = s_r.pins;
endmodule

// >>> sim/pdc_dram_model.sv
// Behavioural model of the page-mode DRAM behind the controller.
module pdc_dram_model (
  input wire pdc_pkg::pdc_pins_s pins,
  output logic [3:0] dq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] mem [logic [21:0]];
  logic [10:0] row;
  logic [10:0] refRow;
  logic [21:0] at;
  logic testMode;
  pdc_pkg::pdc_pins_s p;
  // In test mode the two low column bits are ignored and four words answer as one.
  function automatic logic [3:0] rd_word(input logic [21:0] a);
    logic [15:0] w;
    for (int k = 0; k < 4; k++)
      w[4*k +: 4] = mem.exists({a[21:2], 2'(k)}) ? mem[{a[21:2], 2'(k)}] : 4'h0;
    if (!testMode)
      return mem.exists(a) ? mem[a] : 4'h0;
    return (w == 16'h0000 || w == 16'hFFFF) ? 4'hF : 4'h0;
  endfunction
  initial
  begin
    dq = 4'h5;
    refRow = 11'h000;
    testMode = 1'b0;
    p = '1;
  end
  // A released data line toggles, so the controller never reads a stale word by luck.
  always @(pins)
  begin
    if (!pins.rasN && p.rasN)
      if (!pins.casN)
      begin
        refRow = refRow + 11'h001;
        testMode = !pins.weN;
      end
      else
        row = pins.addr;
    if (!pins.casN && p.casN && !pins.rasN)
      at = {row, pins.addr};
    if (!pins.rasN && !pins.casN && !pins.weN && (p.weN || p.casN))
      for (int k = 0; k < 4; k++)
        if (testMode || k == 0)
          mem[testMode ? {at[21:2], 2'(k)} : at] = pins.dqOut;
    if (!pins.rasN && !pins.casN && !pins.oeN && pins.weN)
      dq <= #(testMode ? 40 : 35) rd_word(at);
    else
      dq <= ~dq;
    p = pins;
  end
endmodule

// >>> sim/pdc_ctrl_monitor.sv
// Checker for the strobe pins and read handshake of the DRAM controller.
module pdc_ctrl_monitor #(
  parameter int unsigned POWERUP_CYC = 20
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic rdValid,
  input wire logic initDone,
  input wire pdc_pkg::pdc_pins_s pins
);
  int unsigned cyc_r;
  logic [3:0] nRefr_r;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  // Counts since reset give the start-up checks their time base.
  always_ff @(posedge ref_clk)
  begin
    cyc_r <= srst ? 0 : cyc_r + 1;
    if (srst)
      nRefr_r <= 4'h0;
    else if ($fell(pins.rasN) && !pins.casN && nRefr_r != 4'hF)
      nRefr_r <= nRefr_r + 4'h1;
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_pause_first: assert property ($fell(pins.rasN) |-> cyc_r >= POWERUP_CYC - 1)
    else $error("row strobe before pause");
  a_init_refresh: assert property ($rose(initDone) |-> nRefr_r >= 4'h8)
    else $error("init done too soon");
  a_refresh_mode: assert property ($fell(pins.rasN) && !pins.casN |-> pins.weN)
    else $error("test mode entered");
  a_wdata_hold: assert property ($fell(pins.casN) && !pins.weN |-> pins.dqOe ##1 $stable(pins.dqOut))
    else $error("write data not held");
  a_oe_off_drive: assert property (pins.dqOe |-> pins.oeN)
    else $error("drive with output on");
  a_row_width: assert property ($fell(pins.rasN) |=> !pins.rasN ##[1:249] pins.rasN)
    else $error("row strobe width");
  a_row_after_cp: assert property ($rose(pins.casN) && !pins.rasN && !$past(pins.oeN) |=> !pins.rasN)
    else $error("row hold after precharge");
  a_read_window: assert property (rdValid |-> !$past(pins.oeN) && !$past(pins.casN))
    else $error("read outside window");
  a_read_select: assert property ($fell(pins.casN) && !pins.rasN && !pins.oeN |-> pins.weN)
    else $error("read without write strobe high");
  c_refresh: cover property ($fell(pins.rasN) && !pins.casN);
  c_page: cover property ($fell(pins.casN) && !pins.rasN && !$past(pins.rasN, 3));
  c_read: cover property (rdValid);
endmodule
bind pdc_ctrl pdc_ctrl_monitor #(.POWERUP_CYC(POWERUP_CYC)) uMon (
  .ref_clk(ref_clk),
  .srst(srst),
  .rdValid(rdValid),
  .initDone(initDone),
  .pins(pins)
);

// >>> sim/pdc_ctrl_tb.sv
// Self-checking bench for the page-mode DRAM controller.
module pdc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned PWR = 20;
  logic ref_clk;
  logic srst;
  pdc_pkg::pdc_req_s req;
  logic reqReady;
  logic [3:0] rdData;
  logic rdValid;
  logic initDone;
  pdc_pkg::pdc_pins_s pins;
  logic [3:0] dqIn;
  logic [3:0] d;
  int n_errors;
  int checks;
  int nRef;
  pdc_ctrl #(.POWERUP_CYC(PWR), .IDLE_CYC(2000), .REFRESH_CYC(200), .TEST_MODE(1'b0)) uut (
    .ref_clk(ref_clk), .srst(srst), .req(req), .reqReady(reqReady), .rdData(rdData),
    .rdValid(rdValid), .initDone(initDone), .pins(pins), .dqIn(dqIn));
  pdc_dram_model uDram (.pins(pins), .dq(dqIn));
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(negedge pins.rasN)
    if (pins.casN === 1'b0)
      nRef++;
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic xfer(input pdc_pkg::pdc_op_e op, input logic [10:0] r, input logic [10:0] c,
    input logic [3:0] w, input logic l, output logic [3:0] q);
    int n;
    @(posedge ref_clk);
    req <= '{1'b1, op, r, c, w, l};
    for (n = 0; n < 500 && reqReady !== 1'b1; n++) @(posedge ref_clk);
    chk({3'h0, reqReady}, 4'h1);
    req.valid <= 1'b0;
    // Writes give no answer beyond the ready pulse.
    for (n = 0; op != pdc_pkg::PDC_WR && n < 100 && rdValid !== 1'b1; n++) @(posedge ref_clk);
    if (op != pdc_pkg::PDC_WR)
      chk({3'h0, rdValid}, 4'h1);
    q = rdData;
  endtask
  task automatic t_init();
    int n;
    srst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    chk({3'h0, initDone}, 4'h0);
    srst <= 1'b0;
    for (n = 0; n < 2000 && initDone !== 1'b1; n++) @(posedge ref_clk);
    chk({3'h0, initDone}, 4'h1);
    chk({3'h0, n >= PWR}, 4'h1);
  endtask
  task automatic t_page();
    for (int i = 0; i < 4; i++)
      xfer(pdc_pkg::PDC_WR, 11'h7FF, 11'(i), 4'(4'hA ^ i), i == 3, d);
    xfer(pdc_pkg::PDC_WR, 11'h000, 11'h7FF, 4'h6, 1'b1, d);
    for (int i = 0; i < 4; i++)
    begin
      xfer(pdc_pkg::PDC_RD, 11'h7FF, 11'(i), 4'h0, i == 3, d);
      chk(d, 4'(4'hA ^ i));
    end
  endtask
  task automatic t_rmw();
    xfer(pdc_pkg::PDC_RMW, 11'h7FF, 11'h001, 4'h3, 1'b1, d);
    chk(d, 4'hB);
    xfer(pdc_pkg::PDC_RD, 11'h7FF, 11'h001, 4'h0, 1'b1, d);
    chk(d, 4'h3);
  endtask
  task automatic t_refresh();
    int k;
    k = nRef;
    repeat (700) @(posedge ref_clk);
    chk({3'h0, nRef - k >= 3}, 4'h1);
    xfer(pdc_pkg::PDC_RD, 11'h000, 11'h7FF, 4'h0, 1'b1, d);
    chk(d, 4'h6);
  endtask
  initial
  begin
    req = '0;
    n_errors = 0;
    checks = 0;
    nRef = 0;
    t_init();
    t_page();
    t_rmw();
    t_refresh();
    t_init();
    xfer(pdc_pkg::PDC_RD, 11'h7FF, 11'h002, 4'h0, 1'b1, d);
    chk(d, 4'h8);
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    print_verdict();
  end
endmodule
